/* rtl/atr_pkg.sv */
// How it works
// - Limits are two 16-bit two's-complement registers
// - High MSB 1, low MSB 0 selects ready
// - Ready: status level single, pulse continuous
// - Low limit pointer 10b, reset 8000h
// - High limit pointer 11b, reset 7FFFh
// - Serial clock is never driven
// - Works with standard, fast, high-speed controllers
// - Four addresses picked by strap pin wiring
// - Write: address, pointer, MSB, LSB stored
// - Pointer 01b selects configuration register
// - Pointer 00b selects result, MSB first
// - Queue 11 disables comparator, pin floats
// - Status reads 0 while busy; write 1 starts single from power-down
package atr_pkg;
    localparam logic [6:0]  ADDR_BASE = 7'h48;
    localparam logic [1:0]  PTR_CONV  = 2'h0;
    localparam logic [1:0]  PTR_CFG   = 2'h1;
    localparam logic [1:0]  PTR_LO    = 2'h2;
    localparam logic [1:0]  PTR_HI    = 2'h3;
    localparam logic [15:0] LO_RST    = 16'h8000;
    localparam logic [15:0] HI_RST    = 16'h7FFF;
    localparam logic [15:0] CFG_RST   = 16'h8583;
    localparam int CFG_OS   = 15;
    localparam int CFG_GAIN = 9;
    localparam int CFG_MODE = 8;
    localparam int CFG_CMP  = 4;
    localparam int CFG_POL  = 3;
    localparam int CFG_LAT  = 2;
    localparam int CFG_QUE  = 0;
    localparam int LIM_MSB  = 15;
    localparam int LIM_LSB  = 4;
    localparam logic [1:0]  QUE_OFF   = 2'h3;
    localparam logic [3:0]  BYTE_BITS = 4'h8;
    localparam logic [2:0]  IDX_ADDR  = 3'h0;
    localparam logic [2:0]  IDX_PTR   = 3'h1;
    localparam logic [2:0]  IDX_MSB   = 3'h2;
    localparam logic [2:0]  IDX_LSB   = 3'h3;
    localparam logic [2:0]  IDX_OVER  = 3'h4;
    localparam int CLK_PERIOD_NS = 8;
    localparam int RDY_PULSE_NS  = 1000;
    localparam int RDY_PULSE_CYC =
        (RDY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK  = 5'h04,
        ST_SEND = 5'h08,
        ST_MACK = 5'h10
    } atr_i2c_st_t;
endpackage : atr_pkg

/* rtl/atr_pin_sync.sv */
`timescale 1ns/1ps
module atr_pin_sync
    import atr_pkg::*;
(
    input  wire logic clk_i,       // System clock
    input  wire logic srst_i,      // Sync reset, high
    input  wire logic scl_i,       // Serial clock pin
    input  wire logic sda_i,       // Serial data pin level
    input  wire logic addr_i,      // Address strap pin
    output logic      scl_s_o,     // Synced clock
    output logic      sda_s_o,     // Synced data
    output logic      addr_s_o,    // Synced strap
    output logic      scl_rise_o,  // Clock rising pulse
    output logic      scl_fall_o,  // Clock falling pulse
    output logic      start_o,     // START pulse
    output logic      stop_o       // STOP pulse
);
    // Bit order {addr, sda, scl}; clock is input only
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } atr_sync_st_t;

    atr_sync_st_t r;
    atr_sync_st_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = {addr_i, sda_i, scl_i};
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r <= {9{1'b1}};
        end else begin
            r <= next_r;
        end
    end

    // Strap and data share one sync depth so their comparison is fair
    assign scl_s_o    = r.s2[0];
    assign sda_s_o    = r.s2[1];
    assign addr_s_o   = r.s2[2];
    assign scl_rise_o = r.s2[0] & ~r.s3[0];
    assign scl_fall_o = ~r.s2[0] & r.s3[0];
    assign start_o    = r.s2[0] & r.s3[0] & r.s3[1] & ~r.s2[1];
    assign stop_o     = r.s2[0] & r.s3[0] & ~r.s3[1] & r.s2[1];
endmodule : atr_pin_sync

/* rtl/atr_alert.sv */
`timescale 1ns/1ps
module atr_alert
    import atr_pkg::*;
(
    input  wire logic        clk_i,       // System clock
    input  wire logic        srst_i,      // Sync reset, high
    input  wire logic [15:0] lo_i,        // Low limit register
    input  wire logic [15:0] hi_i,        // High limit register
    input  wire logic        win_i,       // Window comparator
    input  wire logic        pol_i,       // Active-high pin
    input  wire logic        latch_i,     // Latching comparator
    input  wire logic [1:0]  que_i,       // Queue field
    input  wire logic        cont_i,      // Continuous mode
    input  wire logic [11:0] code_i,      // Conversion code
    input  wire logic        done_i,      // Conversion done pulse
    input  wire logic        busy_i,      // Conversion running
    input  wire logic        rd_i,        // Result read pulse
    output logic             alert_o,     // Alert pin level
    output logic             alert_oe_o   // Alert pin enable
);
    typedef struct packed {
        logic [2:0] cnt;
        logic       act;
        logic [6:0] pulse;
        logic       pin;
        logic       oe;
    } atr_alert_st_t;

    atr_alert_st_t r;
    atr_alert_st_t next_r;
    logic          rdy_mode;
    logic          over;
    logic          under;
    logic [2:0]    need;
    logic          active;

    assign rdy_mode = hi_i[LIM_MSB] & ~lo_i[LIM_MSB];
    // Limit low nibble is ignored
    assign over  = $signed(code_i) > $signed(hi_i[LIM_MSB:LIM_LSB]);
    assign under = $signed(code_i) < $signed(lo_i[LIM_MSB:LIM_LSB]);
    assign need  = (que_i == 2'h0) ? 3'h1 : (que_i == 2'h1) ? 3'h2 : 3'h4;

    always_comb begin
        next_r = r;
        if (r.pulse != 7'h00) begin
            next_r.pulse = r.pulse - 7'h01;
        end
        if (latch_i && rd_i) begin
            next_r.act = 1'b0;
        end
        if (done_i && cont_i) begin
            next_r.pulse = 7'(RDY_PULSE_CYC);
        end
        if (done_i) begin
            if (over || (win_i && under)) begin
                if (r.cnt != need) begin
                    next_r.cnt = r.cnt + 3'h1;
                end
                // Set beats a same-cycle read clear
                if (r.cnt + 3'h1 >= need) begin
                    next_r.act = 1'b1;
                end
            end else begin
                next_r.cnt = 3'h0;
                if (!latch_i && (win_i || under)) begin
                    next_r.act = 1'b0;
                end
            end
        end
        if (que_i == QUE_OFF) begin
            next_r.cnt = 3'h0;
            next_r.act = 1'b0;
        end
        if (rdy_mode) begin
            active = cont_i ? (r.pulse != 7'h00) : ~busy_i;
        end else begin
            active = r.act;
        end
        next_r.pin = pol_i ? active : ~active;
        next_r.oe  = (que_i != QUE_OFF);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r <= '{cnt: 3'h0, act: 1'b0, pulse: 7'h00,
                   pin: 1'b1, oe: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign alert_o    = r.pin;
    assign alert_oe_o = r.oe;

    a_off_hiz: assert property (
        @(posedge clk_i) disable iff (srst_i)
        que_i == QUE_OFF |=> !alert_oe_o)
        else $error("alert pin driven while comparator off");

    a_rdy_single: assert property (
        @(posedge clk_i) disable iff (srst_i)
        rdy_mode && !cont_i
        |=> alert_o == ($past(pol_i) ^ $past(busy_i)))
        else $error("ready pin does not follow status bit");

    a_rdy_pulse: assert property (
        @(posedge clk_i) disable iff (srst_i)
        rdy_mode && cont_i && done_i && !pol_i
        ##1 (rdy_mode && cont_i && !pol_i)
        |=> !alert_o)
        else $error("no ready pulse after conversion");
endmodule : atr_alert

/* rtl/atr_top.sv */
`timescale 1ns/1ps
module atr_top
    import atr_pkg::*;
(
    input  wire logic        clk_i,          // System clock 125 MHz
    input  wire logic        srst_i,         // Sync reset, high
    input  wire logic        scl_i,          // Serial clock pin
    input  wire logic        sda_i,          // Serial data pin level
    output logic             sda_o,          // Serial data drive level
    output logic             sda_oe_o,       // Serial data pull low
    input  wire logic        addr_pin_i,     // Address strap pin
    output logic             alert_o,        // Alert/ready level
    output logic             alert_oe_o,     // Alert/ready enable
    input  wire logic [11:0] conv_code_i,    // Latest result code
    input  wire logic        conv_done_i,    // Conversion done pulse
    input  wire logic        conv_busy_i,    // Conversion running
    output logic             start_single_o, // Start one conversion
    output logic             cont_mode_o,    // Continuous mode
    output logic [2:0]       gain_stage_o    // Gain stage range
);
    typedef struct packed {
        atr_i2c_st_t st;
        logic [7:0]  shift;
        logic [3:0]  cnt;
        logic [2:0]  idx;
        logic        rd;
        logic        half;
        logic [1:0]  ptr;
        logic [7:0]  hold;
        logic [15:0] cfg;
        logic [15:0] low_limit;
        logic [15:0] high_limit;
        logic        seen_hi;
        logic        seen_lo;
        logic        diff_sda;
        logic        sda_low;
        logic        start_p;
        logic        conv_rd;
    } atr_top_st_t;

    atr_top_st_t r;
    atr_top_st_t next_r;

    logic        scl_s;
    logic        sda_s;
    logic        addr_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    logic [6:0]  my_addr;
    logic [15:0] rd_val;
    logic [7:0]  tx_byte;
    logic [15:0] wr_data;
    logic        wr_fire;
    logic        do_load;

    atr_pin_sync u_sync (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .addr_i     (addr_pin_i),
        .scl_s_o    (scl_s),
        .sda_s_o    (sda_s),
        .addr_s_o   (addr_s),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (bus_start),
        .stop_o     (bus_stop)
    );

    // Strap wiring: never high = ground, never low = supply,
    // tracks data = data line, otherwise clock line
    always_comb begin
        if (!r.seen_hi) begin
            my_addr = ADDR_BASE;
        end else if (!r.seen_lo) begin
            my_addr = ADDR_BASE + 7'h01;
        end else if (!r.diff_sda) begin
            my_addr = ADDR_BASE + 7'h02;
        end else begin
            my_addr = ADDR_BASE + 7'h03;
        end
    end

    always_comb begin
        case (r.ptr)
            PTR_CONV: rd_val = {conv_code_i, 4'h0};
            PTR_CFG:  rd_val = {~conv_busy_i, r.cfg[14:0]};
            PTR_LO:   rd_val = r.low_limit;
            default:  rd_val = r.high_limit;
        endcase
    end

    assign tx_byte = r.half ? rd_val[7:0] : rd_val[15:8];
    assign wr_data = {r.hold, r.shift};

    always_comb begin
        next_r         = r;
        next_r.start_p = 1'b0;
        next_r.conv_rd = 1'b0;
        wr_fire        = 1'b0;
        do_load        = 1'b0;
        if (r.st == ST_RECV && r.idx == IDX_ADDR) begin
            next_r.seen_hi  = r.seen_hi | addr_s;
            next_r.seen_lo  = r.seen_lo | ~addr_s;
            next_r.diff_sda = r.diff_sda | (addr_s ^ sda_s);
        end
        if (bus_start) begin
            // Repeated START restarts the frame as well
            next_r.st       = ST_RECV;
            next_r.cnt      = 4'h0;
            next_r.idx      = IDX_ADDR;
            next_r.sda_low  = 1'b0;
            next_r.seen_hi  = 1'b0;
            next_r.seen_lo  = 1'b0;
            next_r.diff_sda = 1'b0;
        end else if (bus_stop) begin
            next_r.st      = ST_IDLE;
            next_r.sda_low = 1'b0;
        end else begin
            case (r.st)
                ST_IDLE: begin
                    next_r.sda_low = 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise && r.cnt != BYTE_BITS) begin
                        next_r.shift = {r.shift[6:0], sda_s};
                        next_r.cnt   = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == BYTE_BITS) begin
                        next_r.st      = ST_ACK;
                        next_r.sda_low = 1'b1;
                        next_r.cnt     = 4'h0;
                        next_r.idx     = r.idx + 3'h1;
                        case (r.idx)
                            IDX_ADDR: begin
                                // Master codes never match: HS entry
                                // is left unacknowledged
                                if (r.shift[7:1] != my_addr) begin
                                    next_r.st      = ST_IDLE;
                                    next_r.sda_low = 1'b0;
                                end
                                next_r.rd   = r.shift[0];
                                next_r.half = 1'b0;
                            end
                            IDX_PTR: begin
                                next_r.ptr = r.shift[1:0];
                            end
                            IDX_MSB: begin
                                next_r.hold = r.shift;
                            end
                            IDX_LSB: begin
                                wr_fire = 1'b1;
                            end
                            default: begin
                                next_r.st      = ST_IDLE;
                                next_r.idx     = IDX_OVER;
                                next_r.sda_low = 1'b0;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_r.sda_low = 1'b0;
                        if (r.rd) begin
                            do_load = 1'b1;
                        end else begin
                            next_r.st = ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (r.cnt == BYTE_BITS) begin
                            next_r.sda_low = 1'b0;
                            next_r.st      = ST_MACK;
                        end else begin
                            next_r.sda_low = ~r.shift[7];
                            next_r.shift   = {r.shift[6:0], 1'b0};
                            next_r.cnt     = r.cnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise && sda_s) begin
                        next_r.st = ST_IDLE;
                    end else if (scl_fall) begin
                        do_load = 1'b1;
                    end
                end
                default: begin
                    next_r.st      = ST_IDLE;
                    next_r.sda_low = 1'b0;
                end
            endcase
        end
        if (do_load) begin
            next_r.st      = ST_SEND;
            next_r.sda_low = ~tx_byte[7];
            next_r.shift   = {tx_byte[6:0], 1'b0};
            next_r.cnt     = 4'h1;
            next_r.half    = ~r.half;
            next_r.conv_rd = r.half && (r.ptr == PTR_CONV);
        end
        if (wr_fire) begin
            case (r.ptr)
                PTR_CFG: begin
                    next_r.cfg = wr_data;
                    // Start only from power-down, else ignored
                    next_r.start_p = wr_data[CFG_OS] & ~conv_busy_i
                                   & r.cfg[CFG_MODE];
                end
                PTR_LO: next_r.low_limit = wr_data;
                PTR_HI: next_r.high_limit = wr_data;
                default: begin
                    next_r.hold = r.hold;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r            <= '0;
            r.st         <= ST_IDLE;
            r.cfg        <= CFG_RST;
            r.low_limit  <= LO_RST;
            r.high_limit <= HI_RST;
        end else begin
            r <= next_r;
        end
    end

    atr_alert u_alert (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .lo_i       (r.low_limit),
        .hi_i       (r.high_limit),
        .win_i      (r.cfg[CFG_CMP]),
        .pol_i      (r.cfg[CFG_POL]),
        .latch_i    (r.cfg[CFG_LAT]),
        .que_i      (r.cfg[CFG_QUE+1:CFG_QUE]),
        .cont_i     (~r.cfg[CFG_MODE]),
        .code_i     (conv_code_i),
        .done_i     (conv_done_i),
        .busy_i     (conv_busy_i),
        .rd_i       (r.conv_rd),
        .alert_o    (alert_o),
        .alert_oe_o (alert_oe_o)
    );

    // Open drain: only ever pulls low
    assign sda_o          = 1'b0;
    assign sda_oe_o       = r.sda_low;
    assign start_single_o = r.start_p;
    assign cont_mode_o    = ~r.cfg[CFG_MODE];
    assign gain_stage_o   = r.cfg[CFG_GAIN+2:CFG_GAIN];

    a_lo_reset: assert property (
        @(posedge clk_i) $fell(srst_i) |-> r.low_limit == LO_RST)
        else $error("low limit reset value wrong");

    a_hi_reset: assert property (
        @(posedge clk_i) $fell(srst_i) |-> r.high_limit == HI_RST)
        else $error("high limit reset value wrong");

    a_ack_low: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_ACK && !scl_fall && !bus_start && !bus_stop
        |=> sda_oe_o)
        else $error("acknowledge not held low");

    a_lo_write: assert property (
        @(posedge clk_i) disable iff (srst_i)
        wr_fire && r.ptr == PTR_LO && !bus_start && !bus_stop
        |=> r.low_limit == $past(wr_data))
        else $error("low limit write lost");

    a_addr_nack: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_RECV && r.idx == IDX_ADDR && scl_fall
        && r.cnt == BYTE_BITS && r.shift[7:1] != my_addr
        && !bus_start && !bus_stop
        |=> r.st == ST_IDLE && !sda_oe_o)
        else $error("foreign address acknowledged");

    a_ptr_load: assert property (
        @(posedge clk_i) disable iff (srst_i)
        r.st == ST_RECV && r.idx == IDX_PTR && scl_fall
        && r.cnt == BYTE_BITS && !bus_start && !bus_stop
        |=> r.ptr == $past(r.shift[1:0]))
        else $error("pointer not taken");

    a_os_pulse: assert property (
        @(posedge clk_i) disable iff (srst_i)
        start_single_o |=> !start_single_o)
        else $error("start pulse longer than one cycle");

    a_conv_msb: assert property (
        @(posedge clk_i) disable iff (srst_i)
        do_load && r.ptr == PTR_CONV && !r.half
        |=> r.shift[7:1] == $past(conv_code_i[10:4]))
        else $error("result MSB not sent first");
endmodule : atr_top

/* tb/atr_i2c_host.sv */
`timescale 1ns/1ps
module atr_i2c_host (
    input  wire logic clk_i,     // System clock
    input  wire logic sda_i,     // Resolved data line
    output logic      scl_o,     // Serial clock, driven by host only
    output logic      sda_low_o  // High while host pulls data low
);
    int q = 5; // Quarter bit in clocks; bench slows it for some

    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // Also serves as repeated start when the clock is low
    task automatic start();
        sda_low_o <= 1'b0;
        cyc(q);
        scl_o <= 1'b1;
        cyc(q);
        sda_low_o <= 1'b1;
        cyc(q);
        scl_o <= 1'b0;
        cyc(q);
    endtask : start

    task automatic stop();
        sda_low_o <= 1'b1;
        cyc(q);
        scl_o <= 1'b1;
        cyc(q);
        sda_low_o <= 1'b0;
        cyc(q);
    endtask : stop

    // Data moves q clocks after the clock falls, long enough for a
    // strap tied to the data line when q is 13 or more
    task automatic bit_x(input logic b, output logic r);
        sda_low_o <= ~b;
        cyc(q);
        scl_o <= 1'b1;
        cyc(q);
        r = sda_i;
        cyc(q);
        scl_o <= 1'b0;
        cyc(q);
    endtask : bit_x

    // last=1 releases the ack slot; ack reports a low line there
    task automatic xfer(input logic [7:0] tx, input logic last,
                        output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx[i] = r;
        end
        bit_x(last, r);
        ack = ~r;
    endtask : xfer
endmodule : atr_i2c_host

/* tb/atr_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end
module atr_tb_top;
    import atr_pkg::*;
    logic        clk_i       = 1'b0;
    logic        srst_i      = 1'b1;
    logic [11:0] conv_code_i = 12'h000;
    logic        conv_done_i = 1'b0;
    logic        conv_busy_i = 1'b0;
    logic [1:0]  strap       = 2'h0;
    logic        seen_start  = 1'b0;
    logic [11:0] codes [4]   = '{12'hF80, 12'h200, 12'h080, 12'hE00};
    logic [3:0]  exp_al      = 4'b0101;
    logic        scl, host_low, sda, sda_o, sda_oe_o, addr_pin;
    logic        alert_o, alert_oe_o, start_single_o, cont_mode_o;
    logic [2:0]  gain_stage_o;
    logic [15:0] rd;
    int          fails       = 0;
    int          compares    = 0;
    int          cycles      = 0;
    localparam int LIMIT = 60000;

    always #4 clk_i = ~clk_i;
    // Pull-up on the data line: high unless someone pulls it low
    assign sda = ~(host_low | (sda_oe_o & ~sda_o));
    assign addr_pin = (strap == 2'h0) ? 1'b0 : (strap == 2'h1) ? 1'b1 :
                      (strap == 2'h2) ? sda : scl;

    atr_i2c_host host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
                       .sda_low_o(host_low));
    atr_top dut (.clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_pin_i(addr_pin),
        .alert_o(alert_o), .alert_oe_o(alert_oe_o),
        .conv_code_i(conv_code_i), .conv_done_i(conv_done_i),
        .conv_busy_i(conv_busy_i), .start_single_o(start_single_o),
        .cont_mode_o(cont_mode_o), .gain_stage_o(gain_stage_o));

    always @(posedge clk_i) if (start_single_o) seen_start <= 1'b1;

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            finish_test();
        end
    end

    task automatic wr_reg(input logic [6:0] a, input logic [1:0] p,
                          input logic [15:0] d, input logic exp_ack);
        logic [7:0] rx;
        logic       ack;
        host.start();
        host.xfer({a, 1'b0}, 1'b1, rx, ack);
        `CHK(ack, exp_ack)
        if (ack) begin
            host.xfer({6'h00, p}, 1'b1, rx, ack);
            host.xfer(d[15:8], 1'b1, rx, ack);
            host.xfer(d[7:0], 1'b1, rx, ack);
            `CHK(ack, 1'b1)
        end
        host.stop();
    endtask : wr_reg

    task automatic rd_reg(input logic [6:0] a, input logic [1:0] p,
                          output logic [15:0] d);
        logic [7:0] rx;
        logic       ack;
        host.start();
        host.xfer({a, 1'b0}, 1'b1, rx, ack);
        host.xfer({6'h00, p}, 1'b1, rx, ack);
        host.start();
        host.xfer({a, 1'b1}, 1'b1, rx, ack);
        host.xfer(8'hFF, 1'b0, d[15:8], ack);
        host.xfer(8'hFF, 1'b1, d[7:0], ack);
        host.stop();
    endtask : rd_reg

    task automatic conv(input logic [11:0] c);
        conv_code_i <= c;
        conv_done_i <= 1'b1;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : conv

    initial begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK({sda_oe_o, alert_oe_o, cont_mode_o}, 3'h0)
        `CHK(gain_stage_o, 3'h2)
        rd_reg(ADDR_BASE, PTR_LO, rd);
        `CHK(rd, 16'h8000)
        rd_reg(ADDR_BASE, PTR_HI, rd);
        `CHK(rd, 16'h7FFF)
        for (int s = 0; s < 4; s++) begin
            strap  <= s[1:0];
            host.q = (s == 2) ? 13 : 5;
            wr_reg(ADDR_BASE + 7'(s), PTR_HI, 16'h1230 + 16'(s), 1'b1);
            rd_reg(ADDR_BASE + 7'(s), PTR_HI, rd);
            `CHK(rd, 16'h1230 + 16'(s))
        end
        strap  <= 2'h0;
        host.q = 5;
        wr_reg(ADDR_BASE + 7'h1, PTR_LO, 16'h0000, 1'b0);
        // Continuous, gain 5, window comparator, one-exceedance queue
        wr_reg(ADDR_BASE, PTR_CFG, 16'h0A90, 1'b1);
        `CHK({cont_mode_o, gain_stage_o, alert_oe_o}, 5'h1B)
        rd_reg(ADDR_BASE, PTR_CFG, rd);
        `CHK(rd, 16'h8A90)
        wr_reg(ADDR_BASE, PTR_LO, 16'hF00F, 1'b1);
        wr_reg(ADDR_BASE, PTR_HI, 16'h100F, 1'b1);
        for (int i = 0; i < 4; i++) begin
            conv(codes[i]);
            `CHK(alert_o, exp_al[i])
        end
        wr_reg(ADDR_BASE, PTR_HI, 16'h8000, 1'b1);
        wr_reg(ADDR_BASE, PTR_LO, 16'h0000, 1'b1);
        conv(12'h123);
        `CHK(alert_o, 1'b0)
        repeat (RDY_PULSE_CYC) @(posedge clk_i);
        `CHK(alert_o, 1'b1)
        wr_reg(ADDR_BASE, PTR_CFG, 16'h0580, 1'b1);
        conv_busy_i <= 1'b1;
        rd_reg(ADDR_BASE, PTR_CFG, rd);
        `CHK(rd, 16'h0580)
        `CHK(alert_o, 1'b1)
        conv_busy_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK(alert_o, 1'b0)
        `CHK(seen_start, 1'b0)
        wr_reg(ADDR_BASE, PTR_CFG, 16'h8580, 1'b1);
        `CHK(seen_start, 1'b1)
        conv(12'hA5C);
        rd_reg(ADDR_BASE, PTR_CONV, rd);
        `CHK(rd, 16'hA5C0)
        wr_reg(ADDR_BASE, PTR_CONV, 16'h1234, 1'b1);
        rd_reg(ADDR_BASE, PTR_CONV, rd);
        `CHK(rd, 16'hA5C0)
        wr_reg(ADDR_BASE, PTR_CFG, 16'h0583, 1'b1);
        `CHK(alert_oe_o, 1'b0)
        wr_reg(ADDR_BASE, PTR_HI, 16'h100F, 1'b1);
        wr_reg(ADDR_BASE, PTR_LO, 16'hF00F, 1'b1);
        // Traditional, active high, latching, two-exceedance queue
        wr_reg(ADDR_BASE, PTR_CFG, 16'h050D, 1'b1);
        conv(12'h200);
        `CHK(alert_o, 1'b0)
        conv(12'h200);
        `CHK(alert_o, 1'b1)
        // Below the low limit would clear a non-latching pin
        conv(12'hE00);
        `CHK(alert_o, 1'b1)
        rd_reg(ADDR_BASE, PTR_CONV, rd);
        `CHK({rd, alert_o}, {16'hE000, 1'b0})
        finish_test();
    end
endmodule : atr_tb_top
